//--- verilog/ifi_defs.vh
// Constants for the increment-file-register instruction block.
// Assumes inclusion by bare name from the design files.
`ifndef IFI_DEFS_VH
`define IFI_DEFS_VH
`define IFI_OPC_HI        15
`define IFI_OPC_LO        10
`define IFI_OPC_VAL       6'h0a
`define IFI_DEST_BIT      9
`define IFI_ACC_BIT       8
`define IFI_ADDR_HI       7
`define IFI_ADDR_LO       0
`define IFI_ST_C          0
`define IFI_ST_DC         1
`define IFI_ST_Z          2
`define IFI_ST_OV         3
`define IFI_ST_N          4
`define IFI_ST_RST        5'h00
`define IFI_WORKING_REGISTER_RST      8'h00
`define IFI_BSR_RST       4'h0
`define IFI_ACC_SPLIT     8'h80
`define IFI_ACC_HI_BANK   4'hf
`define IFI_INC_ONE       8'h01
`define IFI_INC_NIB       5'h01
`endif

//--- verilog/ifi_file_mem.v
// Data memory: banked file registers, registered read data.
// Assumes one write port and one read port on CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
module ifi_file_mem #(
    parameter AW = 12,
    parameter DW = 8
) (
    input  wire          clk,    // System clock
    input  wire          we,     // Write strobe
    input  wire [AW-1:0] waddr,  // Write address
    input  wire [DW-1:0] wdata,  // Write data
    input  wire          re,     // Read strobe
    input  wire [AW-1:0] raddr,  // Read address
    output reg  [DW-1:0] rdata   // Registered read data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule // ifi_file_mem
`default_nettype wire

//--- verilog/ifi_core.v
// Executes the increment-file-register instruction over four phases.
// Assumes INSTR is held stable by the fetch logic through a cycle.
// Functional notes
// - Addressed file register plus one to destination.
// - Update C, DC, N, OV, Z only.
// - Recognise opcode 001010 d a ffffffff.
// - Operands: 8-bit address, destination, access selectors.
// - Destination 0 working register, 1 file.
// - Access 0 access bank, 1 bank select.
`timescale 1ns/1ps
`default_nettype none
`include "ifi_defs.vh"
module ifi_core #(
    parameter AW = 12
) (
    input  wire        CLK_SYS,       // 200 MHz system clock
    input  wire        SYS_RST,       // Synchronous reset, active high
    input  wire        INSTR_VALID,   // Instruction word present
    input  wire [15:0] INSTR,         // Instruction word
    input  wire [3:0]  BANK_SEL_IN,   // New bank_select_register value
    input  wire        BANK_SEL_WE,   // Load bank_select_register
    input  wire        MEM_WE,        // External file write strobe
    input  wire [AW-1:0] MEM_WADDR,   // External file write address
    input  wire [7:0]  MEM_WDATA,     // External file write data
    output reg  [7:0]  WORKING_REG,   // working_register contents
    output reg  [3:0]  BANK_SEL,      // bank_select_register contents
    output reg  [4:0]  STATUS,        // N OV Z DC C flags
    output reg  [1:0]  PHASE,         // Current phase 0..3
    output wire        OP_HIT,        // Decoded increment op this cycle
    output reg         DONE           // One-cycle pulse after write phase
);
    localparam [3:0] Q1 = 4'b0001;
    localparam [3:0] Q2 = 4'b0010;
    localparam [3:0] Q3 = 4'b0100;
    localparam [3:0] Q4 = 4'b1000;

    // Phase numbers shown on PHASE
    localparam [1:0] PH_DECODE  = 2'h0;
    localparam [1:0] PH_READ    = 2'h1;
    localparam [1:0] PH_PROCESS = 2'h2;
    localparam [1:0] PH_WRITE   = 2'h3;

    reg  [3:0]    state_r;
    reg  [3:0]    state_nxt;
    reg           active_r;
    reg           active_nxt;
    reg           dest_r;
    reg           dest_nxt;
    reg  [AW-1:0] faddr_r;
    reg  [AW-1:0] faddr_nxt;
    reg  [7:0]    sum_r;
    reg  [7:0]    sum_nxt;
    reg  [4:0]    flags_r;
    reg  [4:0]    flags_nxt;
    reg  [7:0]    working_register_nxt;
    reg  [3:0]    bsel_nxt;
    reg  [4:0]    status_nxt;
    reg  [1:0]    phase_nxt;
    reg           done_nxt;
    wire [7:0]    rdata;
    wire [AW-1:0] op_addr;
    wire [7:0]    sum8;
    wire          wb_en;
    wire          mem_re;
    wire          mem_we;
    wire [AW-1:0] mem_waddr;
    wire [7:0]    mem_wdata;

    function is_inc_op;
        input [15:0] w;
        begin
            is_inc_op = (w[`IFI_OPC_HI:`IFI_OPC_LO] == `IFI_OPC_VAL);
        end
    endfunction

    // Upper half of the access bank sits in the top bank
    function [AW-1:0] bank_addr;
        input       acc;
        input [3:0] bank_select_register;
        input [7:0] f;
        begin
            bank_addr = {AW{1'b0}};
            if (!acc) begin
                if (f < `IFI_ACC_SPLIT) begin
                    bank_addr[7:0] = f;
                end else begin
                    bank_addr[11:0] = {`IFI_ACC_HI_BANK, f};
                end
            end else begin
                bank_addr[11:0] = {bank_select_register, f};
            end
        end
    endfunction

    // Flags of f + 1, in STATUS bit order
    function [4:0] inc_flags;
        input [7:0] f;
        reg   [8:0] s;
        reg   [4:0] lo;
        begin
            s         = {1'b0, f} + {1'b0, `IFI_INC_ONE};
            lo        = {1'b0, f[3:0]} + `IFI_INC_NIB;
            inc_flags = 5'h00;
            inc_flags[`IFI_ST_C]  = s[8];
            inc_flags[`IFI_ST_DC] = lo[4];
            inc_flags[`IFI_ST_Z]  = (s[7:0] == 8'h00);
            inc_flags[`IFI_ST_OV] = ~f[7] & s[7];
            inc_flags[`IFI_ST_N]  = s[7];
        end
    endfunction

    // Decode only in Q1; other phases ignore INSTR
    assign OP_HIT  = INSTR_VALID && is_inc_op(INSTR) && (state_r == Q1);
    assign op_addr = bank_addr(INSTR[`IFI_ACC_BIT], BANK_SEL, INSTR[`IFI_ADDR_HI:`IFI_ADDR_LO]);
    assign sum8    = rdata + `IFI_INC_ONE;
    assign mem_re  = (state_r == Q2);

    // Next values for every register; one phase per clock
    always @* begin
        state_nxt  = state_r;
        active_nxt = active_r;
        dest_nxt   = dest_r;
        faddr_nxt  = faddr_r;
        sum_nxt    = sum_r;
        flags_nxt  = flags_r;
        working_register_nxt   = WORKING_REG;
        bsel_nxt   = BANK_SEL;
        status_nxt = STATUS;
        phase_nxt  = PHASE;
        done_nxt   = 1'b0;
        if (BANK_SEL_WE) begin
            bsel_nxt = BANK_SEL_IN;
        end
        case (state_r)
            Q1: begin
                state_nxt  = Q2;
                phase_nxt  = PH_READ;
                active_nxt = OP_HIT;
                if (OP_HIT) begin
                    dest_nxt  = INSTR[`IFI_DEST_BIT];
                    faddr_nxt = op_addr;
                end
            end
            Q2: begin
                // File read issued here, data valid in Q3
                state_nxt = Q3;
                phase_nxt = PH_PROCESS;
            end
            Q3: begin
                state_nxt = Q4;
                phase_nxt = PH_WRITE;
                sum_nxt   = sum8;
                flags_nxt = inc_flags(rdata);
            end
            Q4: begin
                state_nxt = Q1;
                phase_nxt = PH_DECODE;
                if (active_r) begin
                    status_nxt = flags_r;
                    done_nxt   = 1'b1;
                    if (!dest_r) begin
                        working_register_nxt = sum_r;
                    end
                end
            end
            default: begin
                state_nxt = Q1;
                phase_nxt = PH_DECODE;
            end
        endcase
    end

    // All registers move on one edge; reset is synchronous
    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_r     <= Q1;
            active_r    <= 1'b0;
            dest_r      <= 1'b1;
            faddr_r     <= {AW{1'b0}};
            sum_r       <= 8'h00;
            flags_r     <= `IFI_ST_RST;
            WORKING_REG <= `IFI_WORKING_REGISTER_RST;
            BANK_SEL    <= `IFI_BSR_RST;
            STATUS      <= `IFI_ST_RST;
            PHASE       <= PH_DECODE;
            DONE        <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            active_r    <= active_nxt;
            dest_r      <= dest_nxt;
            faddr_r     <= faddr_nxt;
            sum_r       <= sum_nxt;
            flags_r     <= flags_nxt;
            WORKING_REG <= working_register_nxt;
            BANK_SEL    <= bsel_nxt;
            STATUS      <= status_nxt;
            PHASE       <= phase_nxt;
            DONE        <= done_nxt;
        end
    end

    // Write-back in Q4 wins over an external write in the same cycle
    assign wb_en     = (state_r == Q4) && active_r && dest_r;
    assign mem_we    = wb_en || MEM_WE;
    assign mem_waddr = wb_en ? faddr_r : MEM_WADDR;
    assign mem_wdata = wb_en ? sum_r : MEM_WDATA;

    // Read issued at end of Q2, data valid in Q3
    ifi_file_mem #(.AW(AW), .DW(8)) u_mem (
        .clk   (CLK_SYS),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .re    (mem_re),
        .raddr (faddr_r),
        .rdata (rdata)
    );
endmodule // ifi_core
`default_nettype wire

//--- dv/ifi_core_checker.sv
// Port assertions for ifi_core.
// Assumes bind into ifi_core, one clock.
`timescale 1ns/1ps
`default_nettype none
module ifi_core_checker (
    input wire logic        CLK_SYS,     // Clock
    input wire logic        SYS_RST,     // Reset
    input wire logic        INSTR_VALID, // Valid
    input wire logic [15:0] INSTR,       // Word
    input wire logic [3:0]  BANK_SEL_IN, // Bank in
    input wire logic        BANK_SEL_WE, // Bank load
    input wire logic [7:0]  WORKING_REG, // W
    input wire logic [3:0]  BANK_SEL,    // Bank
    input wire logic [4:0]  STATUS,      // Flags
    input wire logic [1:0]  PHASE,       // Phase
    input wire logic        OP_HIT,      // Hit
    input wire logic        DONE         // Done
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    AST_PHASE: assert property (PHASE == 2'h0 && !SYS_RST |=> PHASE == 2'h1 ##1 PHASE == 2'h2 ##1 PHASE == 2'h3)
        else $error("phase order");
    AST_HIT: assert property (OP_HIT == (PHASE == 2'h0 && INSTR_VALID && INSTR[15:10] == 6'h0a))
        else $error("decode");
    AST_DONE: assert property (OP_HIT |-> ##4 DONE)
        else $error("done late");
    AST_STAT: assert property (!DONE |-> $stable(STATUS))
        else $error("flags moved");
    AST_WST: assert property (!DONE |-> $stable(WORKING_REG))
        else $error("w moved");
    AST_WD1: assert property (DONE && $past(INSTR[9], 4) |-> $stable(WORKING_REG))
        else $error("w written");
    AST_FLAG: assert property (DONE && !$past(INSTR[9], 4) |-> STATUS == {WORKING_REG[7],
        WORKING_REG == 8'h80, WORKING_REG == 8'h00, WORKING_REG[3:0] == 4'h0, WORKING_REG == 8'h00})
        else $error("flags");
    AST_BANK: assert property (BANK_SEL_WE |=> BANK_SEL == $past(BANK_SEL_IN))
        else $error("bank");
endmodule // ifi_core_checker
bind ifi_core ifi_core_checker u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .BANK_SEL_IN(BANK_SEL_IN), .BANK_SEL_WE(BANK_SEL_WE), .WORKING_REG(WORKING_REG),
    .BANK_SEL(BANK_SEL), .STATUS(STATUS), .PHASE(PHASE), .OP_HIT(OP_HIT), .DONE(DONE));
`default_nettype wire

//--- dv/ifi_core_bench.sv
// Self-checking bench for ifi_core.
// Assumes file data is preloaded by the external write port.
`timescale 1ns/1ps
`default_nettype none
module ifi_core_bench;
    logic        clk = 0, rst = 1, vld = 0, bwe = 0, mwe = 0, hit, done;
    logic [15:0] instr = 16'h0000;
    logic [11:0] madr = 12'h000;
    logic [7:0]  mdat = 8'h00, working_register;
    logic [4:0]  stat;
    logic [3:0]  bin = 4'h0, bsel;
    logic [1:0]  ph;
    int          bad_count = 0, comparisons = 0;
    always #2.5 clk = ~clk;
    ifi_core #(.AW(12)) u_ifi_core (.CLK_SYS(clk), .SYS_RST(rst), .INSTR_VALID(vld), .INSTR(instr),
        .BANK_SEL_IN(bin), .BANK_SEL_WE(bwe), .MEM_WE(mwe), .MEM_WADDR(madr), .MEM_WDATA(mdat),
        .WORKING_REG(working_register), .BANK_SEL(bsel), .STATUS(stat), .PHASE(ph), .OP_HIT(hit), .DONE(done));
    // Preload one file byte and load the bank together
    task automatic set(input [11:0] a, input [7:0] d, input [3:0] b);
        @(posedge clk) #1;
        mwe = 1;
        madr = a;
        mdat = d;
        bwe = 1;
        bin = b;
        @(posedge clk) #1;
        mwe = 0;
        bwe = 0;
        comparisons++;
        if (bsel !== b) begin
            $display("ERROR BANK_SEL exp %h got %h", b, bsel);
            bad_count++;
        end
    endtask
    task automatic run(input [15:0] w, input [7:0] ew, input [4:0] es);
        logic eh;
        eh = (w[15:10] == 6'h0a);
        while (ph !== 2'h0) @(posedge clk) #1;
        instr = w;
        vld = 1;
        #1;
        comparisons++;
        if (hit !== eh) begin
            $display("ERROR OP_HIT exp %h got %h", eh, hit);
            bad_count++;
        end
        @(posedge clk) #1;
        vld = 0;
        repeat (3) @(posedge clk);
        #1;
        comparisons++;
        if (working_register !== ew || stat !== es || done !== eh) begin
            $display("ERROR WORKING_REG/STATUS/DONE exp %h/%h/%h got %h/%h/%h", ew, es, eh, working_register, stat, done);
            bad_count++;
        end
        $display("test %h done", w);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 0;
        set(12'h010, 8'hff, 4'h3);
        run(16'h2810, 8'h00, 5'h07);
        set(12'h310, 8'h7f, 4'h3);
        run(16'h2910, 8'h80, 5'h1a);
        run(16'h2b10, 8'h80, 5'h1a);
        run(16'h2910, 8'h81, 5'h10);
        set(12'hf85, 8'h0e, 4'h3);
        run(16'h2885, 8'h0f, 5'h00);
        run(16'h3c85, 8'h0f, 5'h00);
        final_report;
    end
    initial begin
        #20000;
        bad_count++;
        final_report;
    end
endmodule // ifi_core_bench
`default_nettype wire
